// file: inc/fecp_pkg.sv
// constants, codes and types of the fast ethernet coding path
`default_nettype none
package fecp_pkg;
    localparam int LINE_MHZ  = 125;
    localparam int SYM_MHZ   = 25;
    localparam int MID_MHZ   = 31;
    localparam int SLOW_MHZ  = 10;
    localparam int DIV_MID   = 4;
    localparam int DIV_SYM   = LINE_MHZ / SYM_MHZ;
    localparam int ACC10_INC = 2;
    localparam int ACC10_MOD = 25;
    localparam int SYM_W     = 5;
    localparam int LFSR_W    = 11;
    localparam int TAP_A     = 10;
    localparam int TAP_B     = 8;
    localparam logic [10:0] LFSR_SEED = 11'h7FF;
    localparam logic [7:0]  DSC_LOCK_BITS = 8'h3C;
    localparam logic [7:0]  FEF_ONES = 8'h54;
    localparam logic [7:0]  FEF_CLEAR_RUN = 8'hAA;
    localparam logic [4:0]  SYM_IDLE = 5'h1F;
    localparam logic [4:0]  SYM_J    = 5'h18;
    localparam logic [4:0]  SYM_K    = 5'h11;
    localparam logic [4:0]  SYM_T    = 5'h0D;
    localparam logic [4:0]  SYM_R    = 5'h07;
    localparam logic [4:0]  SYM_H    = 5'h04;
    localparam logic [9:0]  SSD_PAT  = 10'h311;
    localparam logic [1:0]  SDC_COPPER = 2'h0;
    localparam logic [1:0]  SDC_FAULT  = 2'h1;
    localparam logic [1:0]  SDC_SIGNAL = 2'h2;
    localparam logic [1:0]  MLT_ZERO = 2'h0;
    localparam logic [1:0]  MLT_POS  = 2'h1;
    localparam logic [1:0]  MLT_NEG  = 2'h3;
    localparam logic [127:0] ENC_TAB = 128'h1D_1C_1B_1A_17_16_13_12_0F_0E_0B_0A_15_14_09_1E;

    typedef enum logic [2:0] {TX_IDLE, TX_K, TX_DATA, TX_R} fecp_tx_st_t;
    typedef enum logic [0:0] {RX_IDLE, RX_FRAME} fecp_rx_st_t;

    function automatic logic [4:0] fecp_enc(input logic [3:0] nib);
        fecp_enc = ENC_TAB[nib*8 +: 5];
    endfunction

    // bit 4 of the result flags a valid data code
    function automatic logic [4:0] fecp_dec(input logic [4:0] sym);
        logic [4:0] r;
        r = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (ENC_TAB[i*8 +: 5] == sym) begin
                r = {1'b1, 4'(i)};
            end
        end
        fecp_dec = r;
    endfunction
endpackage
`default_nettype wire

// file: inc/fecp_scr_if.sv
// link between the coding core and one scrambler or descrambler
`timescale 1ns/1ns
`default_nettype none
interface fecp_scr_if;
    logic step;
    logic din;
    logic clear;
    logic dout;
    logic locked;
    modport core (input step, input din, input clear, output dout, output locked);
    modport user (output step, output din, output clear, input dout, input locked);
endinterface
`default_nettype wire

// file: logic/fecp_scr.sv
// 11-bit lfsr scrambler, or self-synchronising descrambler
`timescale 1ns/1ns
`default_nettype none
module fecp_scr
    import fecp_pkg::*;
#(
    parameter bit DESCR = 1'b0
) (
    input  wire logic   clk_i,
    input  wire logic   nrst_i,
    input  wire logic   ce_i,
    fecp_scr_if.core    sif
);
    logic [LFSR_W-1:0] lfsr;
    logic [LFSR_W-1:0] next_lfsr;
    logic [7:0]        cnt;
    logic [7:0]        next_cnt;
    logic              lock;
    logic              next_lock;
    logic              key;

    assign key = lfsr[TAP_A] ^ lfsr[TAP_B];
    assign sif.dout = sif.din ^ key;
    assign sif.locked = lock | ~DESCR;

    always_comb begin
        next_lfsr = lfsr;
        next_cnt = cnt;
        next_lock = lock;
        if (sif.clear) begin
            next_lock = 1'b0;
            next_cnt = 8'h00;
        end else if (sif.step) begin
            if (DESCR && !lock) begin
                // idle carries all ones, so the line bit inverted is the key
                next_lfsr = {lfsr[LFSR_W-2:0], ~sif.din}; // R22
                if (sif.din == ~key) begin
                    next_cnt = cnt + 8'h01;
                    if (next_cnt == DSC_LOCK_BITS) begin
                        next_lock = 1'b1;
                    end
                end else begin
                    next_cnt = 8'h00;
                end
            end else begin
                next_lfsr = {lfsr[LFSR_W-2:0], key}; // R10
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            lfsr <= LFSR_SEED;
            cnt <= 8'h00;
            lock <= 1'b0;
        end else if (ce_i) begin
            lfsr <= next_lfsr;
            cnt <= next_cnt;
            lock <= next_lock;
        end
    end
endmodule
`default_nettype wire

// file: logic/fecp_core.sv
// transmit and receive coding path of one 10/100 copper or fiber port
// Overview of operation
// R1: MII nibbles from the MAC are serialised into a bit stream at line rate.
// R2: transmit applies 4B/5B coding first, then scrambling.
// R3: scrambled bits go NRZ to NRZI, then to three-level MLT3.
// R4: receive recovers the bit clock from NRZI transitions.
// R5: recovered clock turns the received NRZI back into NRZ.
// R6: receive descrambles first, then 4B/5B decodes.
// R7: decoded receive bits become MII nibbles toward the MAC.
// R8: line, 31.25, 25 and 10 MHz timing ticks come from one reference.
// R9: scrambling uses an 11-bit LFSR, copper mode only.
// R10: the LFSR sequence is maximal, repeating after 2047 bits.
// R11: descrambler applies the same sequence as the transmitter.
// R12: fiber mode bypasses scrambling and MLT3 both ways.
// R13: fiber mode skips auto-negotiation.
// R14: fiber mode disables automatic pair crossover.
// R15: low signal-detect level means copper; above 1V means fiber.
// R16: mid signal-detect level means no fiber signal and far-end fault.
// R17: high signal-detect level means fiber with signal detected.
// R18: systems without fault signalling tie signal-detect high, forcing fiber.
// R19: under far-end fault, idle carries 84 ones then one zero.
// R20: received far-end fault forces link down; transmit stays normal.
// R21: far-end fault is on after reset and can be disabled.
// R22: polynomial x^11+x^9+1; descrambler locks on idle first.
// R23: signal-detect arrives as synchronised three-value class code.
`timescale 1ns/1ns
`default_nettype none
module fecp_core
    import fecp_pkg::*;
#(
    parameter int BIT_CYC  = 16,
    parameter int LOS_BITS = 64
) (
    input  wire logic       clk_i,
    input  wire logic       nrst_i,
    input  wire logic       ce_i,
    input  wire logic       line_clk_i,
    input  wire logic       tx_en_i,
    input  wire logic       tx_er_i,
    input  wire logic [3:0] tx_d_i,
    output logic            tx_nib_stb_o,
    output logic            rx_nib_stb_o,
    output logic            rx_dv_o,
    output logic            rx_er_o,
    output logic [3:0]      rx_d_o,
    output logic [1:0]      tx_mlt3_o,
    output logic            tx_nrzi_o,
    input  wire logic [1:0] rx_mlt3_i,
    input  wire logic       rx_nrzi_i,
    input  wire logic [1:0] fiber_signal_detect_in_i,
    input  wire logic       fef_disable_i,
    output logic            fiber_mode_o,
    output logic            far_end_fault_o,
    output logic            far_end_fault_rx_o,
    output logic            link_up_o,
    output logic            autoneg_en_o,
    output logic            auto_mdix_en_o,
    output logic            tick_125_o,
    output logic            tick_31_o,
    output logic            tick_25_o,
    output logic            tick_10_o
);
    localparam logic [7:0] HALF = 8'(BIT_CYC / 2);
    localparam logic [7:0] LAST = 8'(BIT_CYC - 1);
    localparam logic [7:0] LOSN = 8'(LOS_BITS);

    fecp_scr_if tsif ();
    fecp_scr_if rsif ();
    fecp_scr #(.DESCR(1'b0)) u_scr (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .sif(tsif));
    fecp_scr #(.DESCR(1'b1)) u_dsc (.clk_i(clk_i), .nrst_i(nrst_i), .ce_i(ce_i), .sif(rsif));

    // synchronisers and timing ticks
    logic [5:0] sync1;
    logic [5:0] sync2;
    logic       lclk_d;
    logic [1:0] c31;
    logic [1:0] next_c31;
    logic [2:0] c25;
    logic [2:0] next_c25;
    logic [4:0] acc10;
    logic [4:0] next_acc10;
    logic [3:0] next_ticks;
    logic       bit_tick;
    logic       sym_tick;
    logic [1:0] sd_class;
    logic       fiber;
    logic       fef_en;
    logic       fef_gen;

    assign bit_tick = sync2[0] & ~lclk_d;
    assign sym_tick = bit_tick && (c25 == 3'h0);
    assign sd_class = sync2[5:4]; // R23
    assign fiber = (sd_class != SDC_COPPER); // R15 R18
    assign fef_en = ~fef_disable_i; // R21
    assign fef_gen = fef_en && (sd_class == SDC_FAULT); // R16

    always_comb begin
        next_c31 = c31;
        next_c25 = c25;
        next_acc10 = acc10;
        next_ticks = 4'h0;
        if (bit_tick) begin
            next_c31 = (c31 == 2'(DIV_MID - 1)) ? 2'h0 : c31 + 2'h1; // R8
            next_c25 = (c25 == 3'(DIV_SYM - 1)) ? 3'h0 : c25 + 3'h1;
            next_acc10 = acc10 + 5'(ACC10_INC);
            next_ticks[0] = 1'b1;
            next_ticks[1] = (c31 == 2'h0);
            next_ticks[2] = (c25 == 3'h0);
            if (next_acc10 >= 5'(ACC10_MOD)) begin
                next_acc10 = next_acc10 - 5'(ACC10_MOD);
                next_ticks[3] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            sync1 <= 6'h00;
            sync2 <= 6'h00;
            lclk_d <= 1'b0;
            c31 <= 2'h0;
            c25 <= 3'h0;
            acc10 <= 5'h00;
            {tick_10_o, tick_25_o, tick_31_o, tick_125_o} <= 4'h0;
        end else if (ce_i) begin
            sync1 <= {fiber_signal_detect_in_i, rx_nrzi_i, rx_mlt3_i, line_clk_i};
            sync2 <= sync1;
            lclk_d <= sync2[0];
            c31 <= next_c31;
            c25 <= next_c25;
            acc10 <= next_acc10;
            {tick_10_o, tick_25_o, tick_31_o, tick_125_o} <= next_ticks;
        end
    end

    // transmit path
    fecp_tx_st_t tst;
    fecp_tx_st_t next_tst;
    logic [4:0]  tsh;
    logic [4:0]  next_tsh;
    logic [7:0]  fcnt;
    logic [7:0]  next_fcnt;
    logic        nrzi;
    logic        next_nrzi;
    logic [1:0]  mph;
    logic [1:0]  next_mph;
    logic [1:0]  next_mlt;
    logic [4:0]  sym;
    logic        in_idle;
    logic        nrz;
    logic        line_bit;

    always_comb begin
        next_tst = tst;
        sym = SYM_IDLE;
        tx_nib_stb_o = 1'b0;
        case (tst)
            TX_IDLE: begin
                if (tx_en_i) begin
                    sym = SYM_J;
                    next_tst = TX_K;
                    tx_nib_stb_o = sym_tick;
                end
            end
            TX_K: begin
                sym = SYM_K;
                next_tst = TX_DATA;
                tx_nib_stb_o = sym_tick;
            end
            TX_DATA: begin
                if (tx_en_i) begin
                    sym = tx_er_i ? SYM_H : fecp_enc(tx_d_i); // R2
                    tx_nib_stb_o = sym_tick; // R1
                end else begin
                    sym = SYM_T;
                    next_tst = TX_R;
                end
            end
            TX_R: begin
                sym = SYM_R;
                next_tst = TX_IDLE;
            end
            default: next_tst = TX_IDLE;
        endcase
        if (!sym_tick) begin
            next_tst = tst;
        end
        in_idle = (tst == TX_IDLE) && !(sym_tick && tx_en_i);
        next_tsh = tsh;
        next_fcnt = fcnt;
        nrz = tsh[4];
        if (sym_tick) begin
            nrz = sym[4];
            next_tsh = {sym[3:0], 1'b0};
        end else if (bit_tick) begin
            next_tsh = {tsh[3:0], 1'b0};
        end
        if (bit_tick && in_idle && fef_gen) begin
            nrz = (fcnt != FEF_ONES); // R19
            next_fcnt = (fcnt == FEF_ONES) ? 8'h00 : fcnt + 8'h01;
        end
        tsif.step = bit_tick;
        tsif.din = nrz;
        tsif.clear = 1'b0;
        line_bit = fiber ? nrz : tsif.dout; // R9 R12
        next_nrzi = nrzi;
        next_mph = mph;
        if (bit_tick && line_bit) begin
            next_nrzi = ~nrzi; // R3
            next_mph = mph + 2'h1;
        end
        case (next_mph)
            2'h1: next_mlt = MLT_POS;
            2'h3: next_mlt = MLT_NEG;
            default: next_mlt = MLT_ZERO;
        endcase
        if (fiber) begin
            next_mlt = MLT_ZERO; // R12
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            tst <= TX_IDLE;
            tsh <= SYM_IDLE;
            fcnt <= 8'h00;
            nrzi <= 1'b0;
            mph <= 2'h0;
            tx_mlt3_o <= MLT_ZERO;
        end else if (ce_i) begin
            tst <= next_tst;
            tsh <= next_tsh;
            fcnt <= next_fcnt;
            nrzi <= next_nrzi;
            mph <= next_mph;
            tx_mlt3_o <= next_mlt;
        end
    end

    assign tx_nrzi_o = nrzi;

    // receive path
    fecp_rx_st_t rst_q;
    fecp_rx_st_t next_rst;
    logic [1:0]  lv;
    logic [1:0]  lv_prev;
    logic [1:0]  next_lv_prev;
    logic [1:0]  samp;
    logic [1:0]  next_samp;
    logic [7:0]  ph;
    logic [7:0]  next_ph;
    logic [7:0]  los;
    logic [7:0]  next_los;
    logic [9:0]  win;
    logic [9:0]  next_win;
    logic [2:0]  sc;
    logic [2:0]  next_sc;
    logic [7:0]  ones;
    logic [7:0]  next_ones;
    logic        rfef;
    logic        next_rfef;
    logic        rx_tick;
    logic        rbit;
    logic        plain;
    logic        lost;
    logic [4:0]  dec;
    logic [3:0]  next_rd;
    logic        next_dv;
    logic        next_er;
    logic        next_stb;
    logic        next_link;

    assign lv = fiber ? {1'b0, sync2[3]} : sync2[2:1];
    assign lost = (los >= LOSN);

    always_comb begin
        next_lv_prev = lv;
        next_ph = (ph == LAST) ? 8'h00 : ph + 8'h01;
        if (lv != lv_prev) begin
            next_ph = 8'h00; // R4
        end
        rx_tick = (ph == HALF);
        rbit = (lv != samp); // R5
        next_samp = rx_tick ? lv : samp;
        next_los = los;
        if (rx_tick) begin
            next_los = rbit ? 8'h00 : (lost ? los : los + 8'h01);
        end
        rsif.step = rx_tick;
        rsif.din = rbit;
        rsif.clear = lost || fiber;
        plain = fiber ? rbit : rsif.dout; // R6 R11 R12
        next_win = win;
        next_sc = sc;
        next_rst = rst_q;
        next_rd = rx_d_o;
        next_dv = rx_dv_o;
        next_er = 1'b0;
        next_stb = 1'b0;
        next_ones = ones;
        next_rfef = rfef;
        dec = 5'h00;
        if (rx_tick) begin
            next_win = {win[8:0], plain};
            next_ones = plain ? ((ones == 8'hFF) ? ones : ones + 8'h01) : 8'h00;
            if (!plain && rst_q == RX_IDLE && ones == FEF_ONES) begin
                next_rfef = 1'b1;
            end else if (ones >= FEF_CLEAR_RUN) begin
                next_rfef = 1'b0;
            end
            case (rst_q)
                RX_IDLE: begin
                    if (next_win == SSD_PAT && (rsif.locked || fiber)) begin // R12
                        next_rst = RX_FRAME;
                        next_sc = 3'h0;
                    end
                end
                RX_FRAME: begin
                    next_sc = (sc == 3'(SYM_W - 1)) ? 3'h0 : sc + 3'h1;
                    if (sc == 3'(SYM_W - 1)) begin
                        dec = fecp_dec(next_win[4:0]);
                        if (next_win[4:0] == SYM_T || next_win[4:0] == SYM_IDLE) begin
                            next_rst = RX_IDLE;
                            next_dv = 1'b0;
                        end else begin
                            next_stb = 1'b1; // R7
                            next_dv = 1'b1;
                            next_er = ~dec[4];
                            next_rd = dec[3:0];
                        end
                    end
                end
                default: next_rst = RX_IDLE;
            endcase
        end
        if (lost) begin
            next_rst = RX_IDLE;
            next_dv = 1'b0;
        end
        if (!fiber) begin
            next_rfef = 1'b0;
        end
        if (fiber) begin
            next_link = (sd_class != SDC_FAULT) && !lost && !(fef_en && rfef); // R17 R20
        end else begin
            next_link = rsif.locked && !lost;
        end
    end

    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            rst_q <= RX_IDLE;
            lv_prev <= 2'h0;
            samp <= 2'h0;
            ph <= 8'h00;
            los <= 8'h00;
            win <= 10'h000;
            sc <= 3'h0;
            ones <= 8'h00;
            rfef <= 1'b0;
            rx_d_o <= 4'h0;
            rx_dv_o <= 1'b0;
            rx_er_o <= 1'b0;
            rx_nib_stb_o <= 1'b0;
            link_up_o <= 1'b0;
        end else if (ce_i) begin
            rst_q <= next_rst;
            lv_prev <= next_lv_prev;
            samp <= next_samp;
            ph <= next_ph;
            los <= next_los;
            win <= next_win;
            sc <= next_sc;
            ones <= next_ones;
            rfef <= next_rfef;
            rx_d_o <= next_rd;
            rx_dv_o <= next_dv;
            rx_er_o <= next_er;
            rx_nib_stb_o <= next_stb;
            link_up_o <= next_link;
        end
    end

    // mode outputs follow the synchronised class code
    assign fiber_mode_o = fiber;
    assign far_end_fault_o = fef_gen;
    assign far_end_fault_rx_o = rfef && fef_en;
    assign autoneg_en_o = ~fiber; // R13
    assign auto_mdix_en_o = ~fiber; // R14
endmodule
`default_nettype wire

// file: sim/fecp_core_properties.sv
// assertion checker on the coding path top ports
`timescale 1ns/1ns
`default_nettype none
module fecp_core_properties
    import fecp_pkg::*;
#(
    parameter int BIT_CYC = 16
) (
    input wire logic       clk_i,
    input wire logic       nrst_i,
    input wire logic [1:0] fiber_signal_detect_in_i,
    input wire logic       fef_disable_i,
    input wire logic       tx_nib_stb_o,
    input wire logic [1:0] tx_mlt3_o,
    input wire logic       rx_nib_stb_o,
    input wire logic       rx_dv_o,
    input wire logic       fiber_mode_o,
    input wire logic       far_end_fault_o,
    input wire logic       far_end_fault_rx_o,
    input wire logic       link_up_o,
    input wire logic       autoneg_en_o,
    input wire logic       auto_mdix_en_o,
    input wire logic       tick_125_o,
    input wire logic       tick_31_o,
    input wire logic       tick_25_o,
    input wire logic       tick_10_o
);
    int         gap;
    logic [2:0] n25;
    logic [2:0] n31;
    logic       seen;
    logic       s25;
    logic       s31;
    logic [3:0] n10;
    logic       s10;

    // counts clock cycles between nibble strobes and line ticks between slow ticks, whatever their phase
    always_ff @(posedge clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            gap  <= 0;
            seen <= 1'b0;
            s25  <= 1'b0;
            s31  <= 1'b0;
            n25  <= 3'h0;
            n31  <= 3'h0;
            n10  <= 4'h0;
            s10  <= 1'b0;
        end else begin
            gap  <= tx_nib_stb_o ? 0 : gap + 1;
            seen <= seen | tx_nib_stb_o;
            s25  <= s25 | tick_25_o;
            s31  <= s31 | tick_31_o;
            n25  <= tick_25_o ? 3'h0 : n25 + 3'(tick_125_o);
            n31  <= tick_31_o ? 3'h0 : n31 + 3'(tick_125_o);
            s10  <= s10 | tick_10_o;
            n10  <= tick_10_o ? 4'h0 : n10 + 4'(tick_125_o);
        end
    end

    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (!nrst_i);

    autoneg_mode_a: assert property (autoneg_en_o == !fiber_mode_o)
        else $error("autoneg enable disagrees with mode");
    mdix_mode_a: assert property (auto_mdix_en_o == !fiber_mode_o)
        else $error("crossover enable disagrees with mode");
    class_mode_a: assert property ($stable(fiber_signal_detect_in_i) [*5] |->
        fiber_mode_o == (fiber_signal_detect_in_i != SDC_COPPER))
        else $error("mode does not follow detect class");
    fault_link_a: assert property ((fiber_signal_detect_in_i == SDC_FAULT) [*5] |=> !link_up_o)
        else $error("link up with fiber signal absent");
    rx_fault_link_a: assert property (far_end_fault_rx_o [*2] |-> !link_up_o)
        else $error("link up while far fault received");
    fef_off_a: assert property (fef_disable_i [*3] |-> !far_end_fault_o)
        else $error("fault sent while disabled");
    fef_fiber_a: assert property (far_end_fault_o |-> fiber_mode_o)
        else $error("fault sent outside fiber mode");
    fiber_quiet_a: assert property (fiber_mode_o [*2] |-> tx_mlt3_o == MLT_ZERO)
        else $error("three-level output active in fiber mode");
    mlt_step_a: assert property ($changed(tx_mlt3_o) |-> tx_mlt3_o != 2'h2 &&
        ($past(tx_mlt3_o) == MLT_ZERO || tx_mlt3_o == MLT_ZERO))
        else $error("illegal three-level step");
    nib_gap_a: assert property (tx_nib_stb_o && seen |-> gap >= 5 * BIT_CYC - 2)
        else $error("nibbles taken faster than five bits");
    sym_tick_a: assert property (tick_25_o && s25 |-> n25 + 3'(tick_125_o) == 3'h5)
        else $error("symbol tick not every fifth bit");
    mid_tick_a: assert property (tick_31_o && s31 |-> n31 + 3'(tick_125_o) == 3'h4)
        else $error("quarter tick not every fourth bit");
    // two tenth ticks per 25 line bits, so gaps alternate 13 and 12
    slow_tick_a: assert property (tick_10_o && s10 |-> n10 + 4'(tick_125_o) inside {4'hC, 4'hD})
        else $error("tenth tick spacing wrong");

    cover property (rx_nib_stb_o && rx_dv_o);
    cover property (far_end_fault_o);
    cover property (far_end_fault_rx_o && fiber_mode_o);
endmodule

bind fecp_core fecp_core_properties #(.BIT_CYC(BIT_CYC)) u_fecp_core_properties (
    .clk_i(clk_i), .nrst_i(nrst_i), .fiber_signal_detect_in_i(fiber_signal_detect_in_i),
    .fef_disable_i(fef_disable_i), .tx_nib_stb_o(tx_nib_stb_o), .tx_mlt3_o(tx_mlt3_o),
    .rx_nib_stb_o(rx_nib_stb_o), .rx_dv_o(rx_dv_o), .fiber_mode_o(fiber_mode_o),
    .far_end_fault_o(far_end_fault_o), .far_end_fault_rx_o(far_end_fault_rx_o),
    .link_up_o(link_up_o), .autoneg_en_o(autoneg_en_o), .auto_mdix_en_o(auto_mdix_en_o),
    .tick_125_o(tick_125_o), .tick_31_o(tick_31_o), .tick_25_o(tick_25_o), .tick_10_o(tick_10_o)
);
`default_nettype wire

// file: sim/fecp_line_model.sv
// far-side line model: bit clock, loopback, remote fault pattern
`timescale 1ns/1ns
`default_nettype none
module fecp_line_model
    import fecp_pkg::*;
(
    input  wire logic       tx_nrzi_i,
    input  wire logic [1:0] tx_mlt3_i,
    input  wire logic       cut_i,
    input  wire logic       fef_i,
    output logic            line_clk_o,
    output logic            rx_nrzi_o,
    output logic [1:0]      rx_mlt3_o
);
    logic [6:0] cnt;
    logic       lvl;

    // odd start offset keeps every bit clock edge 2 ns after a system clock rising edge
    initial begin
        line_clk_o = 1'b0;
        cnt = 7'h00;
        lvl = 1'b0;
        #37;
        forever #80 line_clk_o = ~line_clk_o;
    end

    // ones are transitions, so the zero is one bit without a toggle
    always @(posedge line_clk_o) begin
        cnt <= (cnt == 7'h54) ? 7'h00 : cnt + 7'h01;
        lvl <= lvl ^ (cnt != 7'h54);
    end

    // a cut line carries no transitions at all
    assign rx_nrzi_o = cut_i ? 1'b0 : (fef_i ? lvl : tx_nrzi_i);
    assign rx_mlt3_o = cut_i ? MLT_ZERO : tx_mlt3_i;
endmodule
`default_nettype wire

// file: sim/tb.sv
// self-checking bench for the coding path
`timescale 1ns/1ns
`default_nettype none
module tb
    import fecp_pkg::*;
;
    localparam int BC  = 16;
    localparam int LOS = 32;
    logic       clk_i = 1'b0, nrst_i = 1'b0, en = 1'b0, er = 1'b0, fef_off = 1'b0, cut = 1'b0, inj = 1'b0;
    logic [3:0] txd = 4'h0;
    logic [1:0] sdc = SDC_COPPER;
    logic       lclk, rxn, txn, stb, rstb, dv, rer, fib, fef, frx, link, an, mdix;
    logic [3:0] rxd;
    logic [1:0] txm, rxm;
    logic [4:0] tx_q[$], rx_q[$];
    int         ptr, nz, failures, cmp_count;

    fecp_core #(.BIT_CYC(BC), .LOS_BITS(LOS)) u_fecp_core (
        .clk_i(clk_i), .nrst_i(nrst_i), .ce_i(1'b1), .line_clk_i(lclk),
        .tx_en_i(en), .tx_er_i(er), .tx_d_i(txd), .tx_nib_stb_o(stb),
        .rx_nib_stb_o(rstb), .rx_dv_o(dv), .rx_er_o(rer), .rx_d_o(rxd),
        .tx_mlt3_o(txm), .tx_nrzi_o(txn), .rx_mlt3_i(rxm), .rx_nrzi_i(rxn),
        .fiber_signal_detect_in_i(sdc), .fef_disable_i(fef_off), .fiber_mode_o(fib),
        .far_end_fault_o(fef), .far_end_fault_rx_o(frx), .link_up_o(link),
        .autoneg_en_o(an), .auto_mdix_en_o(mdix), .tick_125_o(), .tick_31_o(),
        .tick_25_o(), .tick_10_o()
    );

    fecp_line_model u_fecp_line_model (
        .tx_nrzi_i(txn), .tx_mlt3_i(txm), .cut_i(cut), .fef_i(inj),
        .line_clk_o(lclk), .rx_nrzi_o(rxn), .rx_mlt3_o(rxm)
    );

    always #5 clk_i = ~clk_i;

    // mac side: next nibble after each strobe, collect received nibbles
    always @(posedge clk_i) begin
        if (stb === 1'b1 && en) begin
            if (ptr + 1 < tx_q.size()) begin
                {er, txd} <= tx_q[ptr + 1];
                ptr <= ptr + 1;
            end else begin
                en <= 1'b0;
            end
        end
        if (rstb === 1'b1 && dv === 1'b1) rx_q.push_back({rer, rxd});
        if (txm !== MLT_ZERO) nz++;
    end

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude;
        if (failures == 0 && cmp_count > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask

    // two leading nibbles become the start delimiter and are not received
    task automatic frame(input logic with_er, input logic rx_chk);
        rx_q = {};
        tx_q = {5'h05, 5'h05};
        for (int i = 0; i < 16; i++) tx_q.push_back(5'(i));
        if (with_er) tx_q.push_back(5'h10);
        @(posedge clk_i);
        ptr <= 0;
        {er, txd} <= tx_q[0];
        en <= 1'b1;
        @(posedge clk_i);
        for (int i = 0; i < 3000 && en; i++) @(posedge clk_i);
        check(8'(ptr), 8'(tx_q.size() - 1));
        for (int i = 0; i < 1500 && (rx_q.size() == 0 || dv !== 1'b0); i++) @(posedge clk_i);
        if (rx_chk) begin
            check(8'(rx_q.size()), 8'(tx_q.size() - 2));
            for (int i = 0; i < 16; i++) check(8'(rx_q[i]), 8'(i));
            if (with_er) check(8'(rx_q[16][4]), 8'h01);
        end
    endtask

    task automatic wait_link;
        for (int i = 0; i < 8000 && link !== 1'b1; i++) @(posedge clk_i);
    endtask

    task automatic t_copper;
        wait_link();
        check(8'(link), 8'h01);
        nz = 0;
        frame(1'b1, 1'b1);
        check(8'(nz > 0), 8'h01);
    endtask

    task automatic t_fiber;
        sdc <= SDC_SIGNAL;
        repeat (8) @(posedge clk_i);
        nz = 0;
        check(8'({fib, an, mdix}), 8'h04);
        wait_link();
        check(8'(link), 8'h01);
        frame(1'b0, 1'b1);
        check(8'(nz), 8'h00);
        cut <= 1'b1;
        repeat ((LOS + 4) * BC) @(posedge clk_i);
        check(8'(link), 8'h00);
        cut <= 1'b0;
    endtask

    task automatic t_fault;
        sdc <= SDC_FAULT;
        for (int i = 0; i < 200 && fef !== 1'b1; i++) @(posedge clk_i);
        check(8'({fib, fef}), 8'h03);
        for (int i = 0; i < 5000 && frx !== 1'b1; i++) @(posedge clk_i);
        check(8'({frx, link}), 8'h02);
        fef_off <= 1'b1;
        repeat (4) @(posedge clk_i);
        check(8'(fef), 8'h00);
        fef_off <= 1'b0;
    endtask

    task automatic t_remote;
        sdc <= SDC_SIGNAL;
        inj <= 1'b1;
        repeat (3000) @(posedge clk_i);
        check(8'({frx, link}), 8'h02);
        frame(1'b0, 1'b0);
        inj <= 1'b0;
        wait_link();
        check(8'({frx, link}), 8'h01);
    endtask

    initial begin
        repeat (60000) @(posedge clk_i);
        failures++;
        conclude();
    end

    initial begin
        repeat (8) @(posedge clk_i);
        check(8'({txm, link, an, mdix, fib}), 8'h06);
        nrst_i <= 1'b1;
        t_copper();
        t_fiber();
        t_fault();
        t_remote();
        conclude();
    end
endmodule
`default_nettype wire
